//--- hw/mtcr_pkg.sv
package mtcr_pkg;

   // Geometry
   localparam int NUM_CH   = 5;
   localparam int NUM_GR   = 16;
   localparam int LOCK_MIN = 2;
   localparam int BUF_OFS  = 2;

   // Values after reset or standby, counter wrap limits and gate reserved bits
   localparam logic [15:0] CNT_RST  = 16'h0000;
   localparam logic [15:0] GR_RST   = 16'hFFFF;
   localparam logic [15:0] CNT_MAX  = 16'hFFFF;
   localparam logic [15:0] CNT_ONE  = 16'h0001;
   localparam logic [7:0]  RUN_RST  = 8'h00;
   localparam logic [7:0]  SYNC_RST = 8'h00;
   localparam logic [7:0]  GATE_RST = 8'hC0;
   localparam logic [1:0]  GATE_RSV = 2'h3;

   // Word addresses on the register port
   localparam logic [4:0] ADDR_STAT = 5'h00;
   localparam logic [4:0] ADDR_CNT  = 5'h05;
   localparam logic [4:0] ADDR_GR   = 5'h0A;
   localparam logic [4:0] ADDR_RUN  = 5'h1A;
   localparam logic [4:0] ADDR_SYNC = 5'h1B;
   localparam logic [4:0] ADDR_GATE = 5'h1C;

   // Field positions
   localparam int STAT_WRAP_POS = 4;
   localparam int STAT_RSV_POS  = 6;
   localparam int STAT_DIR_POS  = 7;
   localparam logic [1:0] LET_C = 2'h2;
   localparam logic [1:0] LET_D = 2'h3;

   // Run and lockstep bit position per channel
   localparam logic [4:0][2:0] CH_POS = {3'h7, 3'h6, 3'h2, 3'h1, 3'h0};
   // Channel and letter of each general register, index 15 down to 0
   localparam logic [15:0][2:0] GR_CH = {3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3, 3'h3, 3'h3,
                                         3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
   localparam logic [15:0][1:0] GR_LET = {2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0,
                                          2'h1, 2'h0, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
   // General register index behind each output gate bit 5..0
   localparam logic [5:0][3:0] GATE_IDX = {4'hF, 4'hE, 4'hB, 4'hD, 4'hC, 4'h9};

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } mtcr_bus_req_t;

   typedef struct packed {
      logic [4:0] tick;
      logic [4:0] down_req;
      logic [4:0] phase_mode;
      logic [4:0] ovf_count;
      logic       comp_pwm;
      logic       rsync_pwm;
      logic [4:0] clr_req;
      logic [4:0] buf_a;
      logic [4:0] buf_b;
      logic [4:0] pinfn_wr;
      logic [4:0] wrap_irq_en;
      logic       wrap4_xfer_done;
   } mtcr_cnt_ctrl_t;

   typedef struct packed {
      logic [15:0] capture_mode;
      logic [15:0] capture;
      logic [15:0] match_level;
      logic [15:0] init_level;
      logic [15:0] xfer_done;
   } mtcr_gr_ctrl_t;

   typedef struct packed {
      logic [4:0][15:0]  cnt;
      logic [15:0][15:0] gr;
      logic [4:0]        fv;
      logic [4:0]        fv_seen;
      logic [15:0]       fg;
      logic [15:0]       fg_seen;
      logic [4:0]        run;
      logic [4:0]        sync;
      logic [5:0]        gate;
      logic [15:0]       lvl;
      logic [15:0]       pin;
      logic [4:0]        irq;
      logic [15:0]       rdata;
   } mtcr_state_t;

   localparam mtcr_state_t ST_RST = '{gr: {16{GR_RST}}, default: '0};

endpackage

//--- hw/mtcr_core.sv
`timescale 1ns/1ps
`default_nettype none

module mtcr_core
(
   input  wire logic                     core_clk_in,
   input  wire logic                     reset_n_in,
   input  wire logic                     standby_in,
   input  wire mtcr_pkg::mtcr_bus_req_t  bus_req_in,
   input  wire mtcr_pkg::mtcr_cnt_ctrl_t cnt_ctrl_in,
   input  wire mtcr_pkg::mtcr_gr_ctrl_t  gr_ctrl_in,
   output logic [15:0]                   bus_rdata_out,
   output logic [15:0]                   timer_io_pin_out,
   output logic [4:0]                    wrap_irq_out
);

   mtcr_pkg::mtcr_state_t st;
   mtcr_pkg::mtcr_state_t next_st;

   logic [4:0]       down_eff;
   logic [4:0]       step;
   logic [4:0]       wrap_ev;
   logic [4:0]       wr_cnt;
   logic [4:0]       stop_pwm;
   logic [15:0]      cap_ev;
   logic [15:0]      cmp_ev;
   logic [15:0]      set_ev;
   logic [4:0][3:0]  stat_fg;
   logic             lock_on;
   logic             lock_clr;
   logic             lock_wr;
   logic [15:0]      rd_val;
   logic [15:0]      gate_mask;

   // Next state of the whole block
   always_comb
   begin
      next_st   = st;
      rd_val    = 16'h0000;
      stat_fg   = '0;
      cap_ev    = '0;
      cmp_ev    = '0;
      set_ev    = '0;
      gate_mask = 16'hFFFF;

      // Count direction per channel
      down_eff[0] = 1'b0;
      for (int c = 1; c < 3; c++)
      begin
         down_eff[c] = cnt_ctrl_in.down_req[c] &&
                       (cnt_ctrl_in.phase_mode[c] || cnt_ctrl_in.ovf_count[c]);
      end
      for (int c = 3; c < 5; c++)
      begin
         down_eff[c] = cnt_ctrl_in.down_req[c] && cnt_ctrl_in.comp_pwm;
      end

      // Run, lockstep and gate registers
      if (bus_req_in.wr && bus_req_in.addr == mtcr_pkg::ADDR_RUN)
      begin
         for (int c = 0; c < mtcr_pkg::NUM_CH; c++)
         begin
            next_st.run[c] = bus_req_in.wdata[mtcr_pkg::CH_POS[c]];
         end
      end
      if (bus_req_in.wr && bus_req_in.addr == mtcr_pkg::ADDR_SYNC)
      begin
         for (int c = 0; c < mtcr_pkg::NUM_CH; c++)
         begin
            next_st.sync[c] = bus_req_in.wdata[mtcr_pkg::CH_POS[c]];
         end
      end
      if (bus_req_in.wr && bus_req_in.addr == mtcr_pkg::ADDR_GATE)
      begin
         next_st.gate = bus_req_in.wdata[5:0];
      end

      // Lockstep needs at least two members, or a lone channel would act alone
      lock_on  = ($countones(st.sync) >= mtcr_pkg::LOCK_MIN);
      lock_clr = lock_on && |(cnt_ctrl_in.clr_req & st.sync);
      lock_wr  = 1'b0;
      for (int c = 0; c < mtcr_pkg::NUM_CH; c++)
      begin
         wr_cnt[c] = bus_req_in.wr && bus_req_in.addr == mtcr_pkg::ADDR_CNT + 5'(c);
         lock_wr   = lock_wr || (wr_cnt[c] && st.sync[c] && lock_on);
      end

      // Counters: step, then clear, then master write wins over both
      for (int c = 0; c < mtcr_pkg::NUM_CH; c++)
      begin
         step[c]     = st.run[c] && cnt_ctrl_in.tick[c];
         stop_pwm[c] = st.run[c] && !next_st.run[c] &&
                       (cnt_ctrl_in.comp_pwm || cnt_ctrl_in.rsync_pwm);
         wrap_ev[c]  = step[c] && (down_eff[c] ?
                       (c == 4 && st.cnt[c] == mtcr_pkg::CNT_ONE) :
                       st.cnt[c] == mtcr_pkg::CNT_MAX);
         if (step[c])
         begin
            next_st.cnt[c] = down_eff[c] ? st.cnt[c] - 16'h0001 : st.cnt[c] + 16'h0001;
         end
         if (cnt_ctrl_in.clr_req[c] || (lock_clr && st.sync[c]))
         begin
            next_st.cnt[c] = mtcr_pkg::CNT_RST;
         end
         if (wr_cnt[c] || (lock_wr && st.sync[c]))
         begin
            next_st.cnt[c] = bus_req_in.wdata;
         end
      end

      // Wrap flags: read arms the clear, set wins over any clear
      for (int c = 0; c < mtcr_pkg::NUM_CH; c++)
      begin
         if (bus_req_in.rd && bus_req_in.addr == mtcr_pkg::ADDR_STAT + 5'(c) && st.fv[c])
         begin
            next_st.fv_seen[c] = 1'b1;
         end
         if ((bus_req_in.wr && bus_req_in.addr == mtcr_pkg::ADDR_STAT + 5'(c) &&
              !bus_req_in.wdata[mtcr_pkg::STAT_WRAP_POS] && st.fv_seen[c]) ||
             (c == 4 && cnt_ctrl_in.wrap4_xfer_done))
         begin
            next_st.fv[c]      = 1'b0;
            next_st.fv_seen[c] = 1'b0;
         end
         if (wrap_ev[c])
         begin
            next_st.fv[c] = 1'b1;
         end
         next_st.irq[c] = next_st.fv[c] && cnt_ctrl_in.wrap_irq_en[c];
      end

      // General registers, one pass per register
      for (int i = 0; i < mtcr_pkg::NUM_GR; i++)
      begin
         automatic int         c  = int'(mtcr_pkg::GR_CH[i]);
         automatic logic [1:0] l  = mtcr_pkg::GR_LET[i];
         automatic logic       bf = (l == mtcr_pkg::LET_C && cnt_ctrl_in.buf_a[c]) ||
                                    (l == mtcr_pkg::LET_D && cnt_ctrl_in.buf_b[c]);
         automatic logic       pb = (l < mtcr_pkg::LET_C) &&
                                    (l[0] ? cnt_ctrl_in.buf_b[c] : cnt_ctrl_in.buf_a[c]);
         // A register used as a buffer neither compares nor captures
         cap_ev[i] = !bf && gr_ctrl_in.capture_mode[i] && gr_ctrl_in.capture[i];
         cmp_ev[i] = !bf && !gr_ctrl_in.capture_mode[i] && step[c] &&
                     st.cnt[c] == st.gr[i];
         set_ev[i] = cap_ev[i] || cmp_ev[i];
         if (cap_ev[i])
         begin
            next_st.gr[i] = st.cnt[c];
            if (pb)
            begin
               next_st.gr[4'(i + mtcr_pkg::BUF_OFS)] = st.gr[i];
            end
         end
         if (cmp_ev[i] && pb)
         begin
            next_st.gr[i] = st.gr[4'(i + mtcr_pkg::BUF_OFS)];
         end

         // Pin level holds when halted unless a PWM stop or pin setup
         if (cmp_ev[i])
         begin
            next_st.lvl[i] = gr_ctrl_in.match_level[i];
         end
         if ((!st.run[c] && cnt_ctrl_in.pinfn_wr[c]) || stop_pwm[c])
         begin
            next_st.lvl[i] = gr_ctrl_in.init_level[i];
         end

         // Match/capture flag
         if (bus_req_in.rd && bus_req_in.addr == mtcr_pkg::ADDR_STAT + 5'(c) && st.fg[i])
         begin
            next_st.fg_seen[i] = 1'b1;
         end
         if ((bus_req_in.wr && bus_req_in.addr == mtcr_pkg::ADDR_STAT + 5'(c) &&
              !bus_req_in.wdata[l] && st.fg_seen[i]) || gr_ctrl_in.xfer_done[i])
         begin
            next_st.fg[i]      = 1'b0;
            next_st.fg_seen[i] = 1'b0;
         end
         if (set_ev[i])
         begin
            next_st.fg[i] = 1'b1;
         end
         stat_fg[c][l] = st.fg[i];
      end

      // Master writes to general registers beat capture and buffer moves
      for (int i = 0; i < mtcr_pkg::NUM_GR; i++)
      begin
         if (bus_req_in.wr && bus_req_in.addr == mtcr_pkg::ADDR_GR + 5'(i))
         begin
            next_st.gr[i] = bus_req_in.wdata;
         end
      end

      // Motor pins are gated, the rest pass straight through
      for (int g = 0; g < 6; g++)
      begin
         gate_mask[mtcr_pkg::GATE_IDX[g]] = next_st.gate[g];
      end
      next_st.pin = next_st.lvl & gate_mask;

      // Read data mux; unmapped words read zero
      for (int c = 0; c < mtcr_pkg::NUM_CH; c++)
      begin
         if (bus_req_in.addr == mtcr_pkg::ADDR_STAT + 5'(c))
         begin
            rd_val[3:0]                        = stat_fg[c];
            rd_val[mtcr_pkg::STAT_WRAP_POS]    = st.fv[c];
            rd_val[mtcr_pkg::STAT_RSV_POS]     = 1'b1;
            rd_val[mtcr_pkg::STAT_DIR_POS]     = !down_eff[c];
         end
         if (bus_req_in.addr == mtcr_pkg::ADDR_CNT + 5'(c))
         begin
            rd_val = st.cnt[c];
         end
         rd_val[mtcr_pkg::CH_POS[c]] = rd_val[mtcr_pkg::CH_POS[c]] ||
            (bus_req_in.addr == mtcr_pkg::ADDR_RUN && st.run[c]) ||
            (bus_req_in.addr == mtcr_pkg::ADDR_SYNC && st.sync[c]);
      end
      for (int i = 0; i < mtcr_pkg::NUM_GR; i++)
      begin
         if (bus_req_in.addr == mtcr_pkg::ADDR_GR + 5'(i))
         begin
            rd_val = st.gr[i];
         end
      end
      if (bus_req_in.addr == mtcr_pkg::ADDR_GATE)
      begin
         rd_val = {8'h00, mtcr_pkg::GATE_RSV, st.gate};
      end
      if (bus_req_in.rd)
      begin
         next_st.rdata = rd_val;
      end

      // Standby puts everything back to its reset values
      if (standby_in)
      begin
         next_st = mtcr_pkg::ST_RST;
      end
   end

   // State register; manual reset is not wired here so state survives it
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         st <= mtcr_pkg::ST_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign bus_rdata_out    = st.rdata;
   assign timer_io_pin_out = st.pin;
   assign wrap_irq_out     = st.irq;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);

   for (genvar c = 0; c < 5; c++)
   begin : g_ch_chk
      AST_WRAP_SET: assert property (wrap_ev[c] && !standby_in |=> st.fv[c])
         else $error("wrap flag not set after counter wrap");
      AST_WR_PRIO: assert property (wr_cnt[c] && !standby_in |=>
                                    st.cnt[c] == $past(bus_req_in.wdata))
         else $error("counter write lost");
   end

   for (genvar i = 0; i < 16; i++)
   begin : g_gr_chk
      AST_SET_WINS: assert property (set_ev[i] && !standby_in |=> st.fg[i])
         else $error("flag set event lost");
      AST_CLR_NEEDS_READ: assert property (st.fg[i] && !st.fg_seen[i] && !set_ev[i] &&
                                           !gr_ctrl_in.xfer_done[i] && !standby_in
                                           |=> st.fg[i])
         else $error("flag cleared without prior read");
      AST_CAPTURE: assert property (cap_ev[i] && !standby_in && !bus_req_in.wr |=>
                                    st.gr[i] == $past(st.cnt[mtcr_pkg::GR_CH[i]]))
         else $error("capture did not copy counter");
      AST_XFER_CLR: assert property (gr_ctrl_in.xfer_done[i] && !set_ev[i] |=>
                                     !st.fg[i])
         else $error("transfer completion did not clear flag");
   end

   // Motor pins must stay low while their gate bit is off
   for (genvar g = 0; g < 6; g++)
   begin : g_gate_chk
      AST_PIN_GATED: assert property (!st.gate[g] |->
                                      !timer_io_pin_out[mtcr_pkg::GATE_IDX[g]])
         else $error("motor pin driven while its gate is off");
   end

   AST_CH4_DOWN: assert property (step[4] && down_eff[4] && st.cnt[4] == 16'h0001 &&
                                  !standby_in |=> st.fv[4])
      else $error("channel 4 down wrap flag missing");
   AST_WRAP4_CLR: assert property (cnt_ctrl_in.wrap4_xfer_done && !wrap_ev[4] |=>
                                   !st.fv[4])
      else $error("channel 4 wrap flag not cleared by transfer");
   AST_CD_ZERO: assert property (bus_req_in.rd && bus_req_in.addr == 5'h01 |=>
                                 bus_rdata_out[3:2] == 2'h0)
      else $error("channel 1 flags C/D not zero");
   AST_RUN_RSV: assert property (bus_req_in.rd && bus_req_in.addr == mtcr_pkg::ADDR_RUN
                                 |=> bus_rdata_out[5:3] == 3'h0)
      else $error("run register reserved bits not zero");
   AST_GATE_RSV: assert property (bus_req_in.rd && bus_req_in.addr == mtcr_pkg::ADDR_GATE
                                  |=> bus_rdata_out[7:6] == 2'h3)
      else $error("gate register reserved bits not one");
   AST_STANDBY: assert property (standby_in |=> st.cnt[0] == 16'h0000 &&
                                 st.gr[5] == 16'hFFFF && bus_rdata_out == 16'h0000)
      else $error("standby did not reset registers");
   AST_CH0_UP: assert property (!wr_cnt[0] && !lock_wr && st.cnt[0] != 16'h0001 |=>
                                st.cnt[0] != $past(st.cnt[0]) - 16'h0001)
      else $error("channel 0 counted down");

endmodule

`default_nettype wire

//--- tb/mtcr_xfer_model.sv
`timescale 1ns/1ps
`default_nettype none

// Transfer controllers: a flag or channel 4 wrap request taken while idle is answered by a one-cycle done pulse
module mtcr_xfer_model
#(
   parameter int LAT = 8
)
(
   input  wire logic        core_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic [4:0]  wrap_req_in,
   input  wire logic [15:0] flag_req_in,
   output logic [15:0]      flag_done_out,
   output logic             wrap4_done_out
);
   logic [4:0]  wait_cnt;
   logic [15:0] pend_flag;
   logic        pend_wrap;

   // One move at a time; the gap after each pulse lets a level request fall
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         wait_cnt       <= 5'h00;
         pend_flag      <= 16'h0000;
         pend_wrap      <= 1'b0;
         flag_done_out  <= 16'h0000;
         wrap4_done_out <= 1'b0;
      end
      else
      begin
         flag_done_out  <= 16'h0000;
         wrap4_done_out <= 1'b0;
         if (wait_cnt != 5'h00)
         begin
            wait_cnt <= wait_cnt - 5'h01;
            if (wait_cnt == 5'h02)
            begin
               flag_done_out  <= pend_flag;
               wrap4_done_out <= pend_wrap;
            end
         end
         else if ((flag_req_in != 16'h0000) || wrap_req_in[4])
         begin
            pend_flag <= flag_req_in;
            pend_wrap <= wrap_req_in[4];
            wait_cnt  <= 5'(LAT + 2);
         end
      end
   end
endmodule

`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic                     core_clk;
   logic                     reset_n;
   logic                     standby;
   mtcr_pkg::mtcr_bus_req_t  breq;
   mtcr_pkg::mtcr_cnt_ctrl_t cc;
   mtcr_pkg::mtcr_cnt_ctrl_t cc_dut;
   mtcr_pkg::mtcr_gr_ctrl_t  gc;
   mtcr_pkg::mtcr_gr_ctrl_t  gc_dut;
   logic [15:0]              rdata;
   logic [15:0]              pins;
   logic [15:0]              fdone;
   logic [15:0]              freq;
   logic [4:0]               irq;
   logic                     w4done;
   int                       errors;
   int                       compares;

   mtcr_core DUT (.core_clk_in(core_clk), .reset_n_in(reset_n), .standby_in(standby),
      .bus_req_in(breq), .cnt_ctrl_in(cc_dut), .gr_ctrl_in(gc_dut),
      .bus_rdata_out(rdata), .timer_io_pin_out(pins), .wrap_irq_out(irq));

   mtcr_xfer_model #(.LAT(8)) XFER (.core_clk_in(core_clk), .reset_n_in(reset_n),
      .wrap_req_in(irq), .flag_req_in(freq), .flag_done_out(fdone),
      .wrap4_done_out(w4done));

   // Transfer completions come from the model, the rest from the bench
   always_comb
   begin
      cc_dut = cc;
      cc_dut.wrap4_xfer_done = w4done;
      gc_dut = gc;
      gc_dut.xfer_done = fdone;
   end

   // 40 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic finish_test();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Whole 16-bit words only; byte lanes are never used
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge core_clk);
      breq.wr = 1'b1;
      breq.addr = a;
      breq.wdata = d;
      @(negedge core_clk);
      breq.wr = 1'b0;
   endtask

   // Read data holds until the next read, so it is sampled a cycle late
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      @(negedge core_clk);
      breq.rd = 1'b1;
      breq.addr = a;
      @(negedge core_clk);
      breq.rd = 1'b0;
      @(negedge core_clk);
      chk($sformatf("register %h", a), exp, rdata);
   endtask

   task automatic step(input logic [4:0] m);
      @(negedge core_clk);
      cc.tick = m;
      @(negedge core_clk);
      cc.tick = 5'h00;
   endtask

   // Bounded wait for any transfer completion
   task automatic wait_done(input logic [15:0] f);
      @(negedge core_clk);
      freq = f;
      @(negedge core_clk);
      freq = 16'h0000;
      for (int i = 0; i < 40 && ((|fdone) || w4done) !== 1'b1; i++)
         @(negedge core_clk);
      @(negedge core_clk);
   endtask

   // Hang guard
   initial
   begin
      repeat (6000) @(posedge core_clk);
      errors++;
      finish_test();
   end

   initial
   begin
      errors = 0;
      compares = 0;
      reset_n = 1'b0;
      standby = 1'b0;
      breq = '0;
      cc = '0;
      gc = '0;
      freq = 16'h0000;
      repeat (8) @(negedge core_clk);
      reset_n = 1'b1;
      for (int i = 0; i < 5; i++)
         rd(mtcr_pkg::ADDR_CNT + 5'(i), 16'h0000);
      for (int i = 0; i < 16; i++)
         rd(mtcr_pkg::ADDR_GR + 5'(i), 16'hFFFF);
      rd(mtcr_pkg::ADDR_STAT + 5'h01, 16'h00C0);
      rd(mtcr_pkg::ADDR_RUN, 16'h0000);
      rd(mtcr_pkg::ADDR_SYNC, 16'h0000);
      rd(mtcr_pkg::ADDR_GATE, 16'h00C0);
      rd(5'h1F, 16'h0000);
      // Wrap on channel 0 also hits all four registers at FFFF
      cc.wrap_irq_en = 5'h11;
      wr(mtcr_pkg::ADDR_RUN, 16'h0001);
      wr(mtcr_pkg::ADDR_CNT, 16'hFFFF);
      step(5'h01);
      chk("wrap irq 0", 16'h0001, {15'h0000, irq[0]});
      rd(mtcr_pkg::ADDR_CNT, 16'h0000);
      rd(mtcr_pkg::ADDR_STAT, 16'h00DF);
      wr(mtcr_pkg::ADDR_STAT, 16'h00FF);
      rd(mtcr_pkg::ADDR_STAT, 16'h00DF);
      wr(mtcr_pkg::ADDR_STAT, 16'h0000);
      rd(mtcr_pkg::ADDR_STAT, 16'h00C0);
      chk("wrap irq 0", 16'h0000, {15'h0000, irq[0]});
      // Clearing write without a prior read must not clear
      wr(mtcr_pkg::ADDR_GR, 16'h0005);
      wr(mtcr_pkg::ADDR_CNT, 16'h0005);
      step(5'h01);
      wr(mtcr_pkg::ADDR_STAT, 16'h0000);
      rd(mtcr_pkg::ADDR_STAT, 16'h00C1);
      wait_done(16'h0001);
      rd(mtcr_pkg::ADDR_STAT, 16'h00C0);
      wr(mtcr_pkg::ADDR_GR + 5'h03, 16'h0006);
      step(5'h01);
      rd(mtcr_pkg::ADDR_STAT, 16'h00C8);
      wait_done(16'h0008);
      rd(mtcr_pkg::ADDR_STAT, 16'h00C0);
      // Register C feeds A on a match
      cc.buf_a = 5'h01;
      wr(mtcr_pkg::ADDR_GR + 5'h02, 16'h0030);
      wr(mtcr_pkg::ADDR_GR, 16'h0010);
      wr(mtcr_pkg::ADDR_CNT, 16'h0010);
      step(5'h01);
      cc.buf_a = 5'h00;
      rd(mtcr_pkg::ADDR_GR, 16'h0030);
      // Write lands in a counting cycle
      cc.tick = 5'h01;
      wr(mtcr_pkg::ADDR_CNT, 16'h1234);
      cc.tick = 5'h00;
      rd(mtcr_pkg::ADDR_CNT, 16'h1234);
      // Channel 1 goes down only in phase or cascade counting
      wr(mtcr_pkg::ADDR_RUN, 16'h0003);
      cc.down_req = 5'h02;
      wr(mtcr_pkg::ADDR_CNT + 5'h01, 16'h0005);
      step(5'h02);
      rd(mtcr_pkg::ADDR_CNT + 5'h01, 16'h0006);
      cc.phase_mode = 5'h02;
      step(5'h02);
      rd(mtcr_pkg::ADDR_CNT + 5'h01, 16'h0005);
      cc.phase_mode = 5'h00;
      cc.ovf_count = 5'h02;
      step(5'h02);
      rd(mtcr_pkg::ADDR_CNT + 5'h01, 16'h0004);
      cc.ovf_count = 5'h00;
      cc.down_req = 5'h00;
      // Capture into channel 1 register A
      gc.capture_mode = 16'h0010;
      @(negedge core_clk);
      gc.capture = 16'h0010;
      @(negedge core_clk);
      gc.capture = 16'h0000;
      rd(mtcr_pkg::ADDR_GR + 5'h04, 16'h0004);
      rd(mtcr_pkg::ADDR_STAT + 5'h01, 16'h00C1);
      // Channel 4 stepping down from one
      cc.comp_pwm = 1'b1;
      cc.down_req = 5'h10;
      wr(mtcr_pkg::ADDR_RUN, 16'h0080);
      wr(mtcr_pkg::ADDR_CNT + 5'h04, 16'h0001);
      step(5'h10);
      rd(mtcr_pkg::ADDR_STAT + 5'h04, 16'h0050);
      wait_done(16'h0000);
      rd(mtcr_pkg::ADDR_STAT + 5'h04, 16'h0040);
      rd(mtcr_pkg::ADDR_CNT + 5'h04, 16'h0000);
      cc.comp_pwm = 1'b0;
      cc.down_req = 5'h00;
      // Lockstep preset and clear
      wr(mtcr_pkg::ADDR_SYNC, 16'h0003);
      wr(mtcr_pkg::ADDR_CNT, 16'h0077);
      rd(mtcr_pkg::ADDR_CNT + 5'h01, 16'h0077);
      @(negedge core_clk);
      cc.clr_req = 5'h01;
      @(negedge core_clk);
      cc.clr_req = 5'h00;
      rd(mtcr_pkg::ADDR_CNT + 5'h01, 16'h0000);
      // Reserved bits and an unmapped address
      wr(mtcr_pkg::ADDR_RUN, 16'h00FF);
      rd(mtcr_pkg::ADDR_RUN, 16'h00C7);
      wr(mtcr_pkg::ADDR_SYNC, 16'h00FF);
      rd(mtcr_pkg::ADDR_SYNC, 16'h00C7);
      wr(mtcr_pkg::ADDR_GATE, 16'h0000);
      rd(mtcr_pkg::ADDR_GATE, 16'h00C0);
      wr(mtcr_pkg::ADDR_GATE, 16'h003F);
      rd(mtcr_pkg::ADDR_GATE, 16'h00FF);
      wr(5'h1F, 16'hFFFF);
      rd(5'h1F, 16'h0000);
      // Pin levels: set up while halted, gated, held on halt, reset by PWM stop
      wr(mtcr_pkg::ADDR_RUN, 16'h0000);
      gc.init_level = 16'h1200;
      gc.match_level = 16'h0040;
      cc.pinfn_wr = 5'h18;
      @(negedge core_clk);
      cc.pinfn_wr = 5'h00;
      chk("pins", 16'h1200, pins);
      wr(mtcr_pkg::ADDR_GATE, 16'h0001);
      chk("pins", 16'h0200, pins);
      wr(mtcr_pkg::ADDR_GR + 5'h06, 16'h0000);
      wr(mtcr_pkg::ADDR_RUN, 16'h0004);
      step(5'h04);
      wr(mtcr_pkg::ADDR_RUN, 16'h0000);
      chk("pins", 16'h0240, pins);
      cc.rsync_pwm = 1'b1;
      wr(mtcr_pkg::ADDR_RUN, 16'h0004);
      wr(mtcr_pkg::ADDR_RUN, 16'h0000);
      chk("pins", 16'h0200, pins);
      cc.rsync_pwm = 1'b0;
      // Standby restores reset values
      @(negedge core_clk);
      standby = 1'b1;
      @(negedge core_clk);
      standby = 1'b0;
      rd(mtcr_pkg::ADDR_CNT, 16'h0000);
      rd(mtcr_pkg::ADDR_GR, 16'hFFFF);
      rd(mtcr_pkg::ADDR_GATE, 16'h00C0);
      // Capture on B moves the old B into its buffer D
      cc.buf_b = 5'h01;
      gc.capture_mode = 16'h0002;
      wr(mtcr_pkg::ADDR_GR + 5'h01, 16'h0042);
      wr(mtcr_pkg::ADDR_CNT, 16'h0099);
      @(negedge core_clk);
      gc.capture = 16'h0002;
      @(negedge core_clk);
      gc.capture = 16'h0000;
      cc.buf_b = 5'h00;
      rd(mtcr_pkg::ADDR_GR + 5'h01, 16'h0099);
      rd(mtcr_pkg::ADDR_GR + 5'h03, 16'h0042);
      finish_test();
   end
endmodule

`default_nettype wire
